/* src/sob_defines.svh */
`ifndef SOB_DEFINES_SVH
`define SOB_DEFINES_SVH

// -----------------------------------------------------------------------------
// Serial clock divider
// -----------------------------------------------------------------------------
// Serial clock is the system clock divided by two to this power.
`define SOB_DIV_BITS        10
// Serial clock period in system clock cycles.
`define SOB_SCL_PERIOD      1024

// -----------------------------------------------------------------------------
// Serial memory download
// -----------------------------------------------------------------------------
`define SOB_BITS_PER_BYTE   4'h8
`define SOB_CTRL_READ       8'ha1
`define SOB_LOAD_BYTES      16
`define SOB_IDX_W           8

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define SOB_RST_BIT         1'b0
`define SOB_RST_BYTE        8'h00
`define SOB_RST_BITCNT      4'h0

`endif

/* src/sob_pkg.sv */
package sob_pkg;

   typedef enum logic [2:0]
   {
      SOB_IDLE,
      SOB_START,
      SOB_CTRL,
      SOB_CACK,
      SOB_RDBIT,
      SOB_RACK,
      SOB_STOP
   } sob_load_st_t;

endpackage

/* src/sob_sclk_div.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sob_defines.svh"

module sob_sclk_div
#(
   parameter int DIV_W = `SOB_DIV_BITS
)
(
   input  wire logic sys_clk,
   input  wire logic rst,
   output logic      scl,
   output logic      mid_low,
   output logic      mid_high
);

   localparam logic [DIV_W-1:0] MID_LO = DIV_W'(1) << (DIV_W - 2);
   localparam logic [DIV_W-1:0] MID_HI = MID_LO | (DIV_W'(1) << (DIV_W - 1));

   logic [DIV_W-1:0] cnt_ff;

   initial
   begin
      if (DIV_W < 3)
         $error("sob_sclk_div: DIV_W must be at least 3.");
   end

   // --------------------------------------------------------------------------
   // Free-running counter; its top bit is the serial clock.
   // --------------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cnt_ff <= '0;
      else
         cnt_ff <= cnt_ff + DIV_W'(1);
   end

   assign scl      = cnt_ff[DIV_W-1];
   assign mid_low  = (cnt_ff == MID_LO);
   assign mid_high = (cnt_ff == MID_HI);

   // --------------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------------
   scl_toggle_a : assert property (@(posedge sys_clk) disable iff (rst)
      (cnt_ff[DIV_W-2:0] == '1) |=> (scl != $past(scl)))
      else $error("Serial clock did not toggle at counter wrap.");

   scl_steady_a : assert property (@(posedge sys_clk) disable iff (rst)
      (cnt_ff[DIV_W-2:0] != '1) |=> (scl == $past(scl)))
      else $error("Serial clock toggled away from counter wrap.");

endmodule

`default_nettype wire

/* src/sob_top.sv */
// Summary of operation
// - After reset, a high load strap starts a register download from the memory.
// - After reset, a high serial data line also starts the download.
// - Arbiter strap high at reset release enables the internal bus arbiter.
// - While config-disable is set, hot-swap interrupt is withheld, config cycles retried.
// - Config cycles are accepted once software clears the config-disable bit.
// - Serial clock equals system clock divided by 1024.
// - Power event output asserts on a state change request or power event.
// - Hot-swap output tells the host of board insertion or pending extraction.
// - Reset brings all registers, state machines and outputs to a known state.
`timescale 1ns/1ps
`default_nettype none
`include "sob_defines.svh"

module sob_top
   import sob_pkg::*;
#(
   parameter int LOAD_BYTES = `SOB_LOAD_BYTES,
   parameter int DIV_W      = `SOB_DIV_BITS
)
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       eeprom_load_strap,
   input  wire logic       arbiter_enable_strap,
   input  wire logic       config_disable_option,
   input  wire logic       misc_control_two_wr,
   input  wire logic       misc_control_two_cfg_dis,
   input  wire logic       hs_event,
   input  wire logic       hs_event_clr,
   input  wire logic       pm_event,
   input  wire logic       pm_event_clr,
   input  wire logic       eeprom_sda_i,
   output logic            eeprom_sda_o,
   output logic            eeprom_sda_oe,
   output logic            eeprom_scl,
   output logic            arb_enable,
   output logic            cfg_retry,
   output logic            enum_irq_o,
   output logic            enum_irq_oe,
   output logic            power_event_irq_o,
   output logic            power_event_irq_oe,
   output logic            load_busy,
   output logic            load_done,
   output logic            load_error,
   output logic [7:0]      dl_byte,
   output logic [`SOB_IDX_W-1:0] dl_index,
   output logic            dl_valid
);

   sob_load_st_t          st_ff;
   logic                  samp_done_ff;
   logic                  arb_ff;
   logic                  cfg_dis_ff;
   logic                  enum_pend_ff;
   logic                  pme_pend_ff;
   logic                  sda_oe_ff;
   logic [7:0]            shift_ff;
   logic [3:0]            bit_ff;
   logic [`SOB_IDX_W-1:0] idx_ff;
   logic                  valid_ff;
   logic                  done_ff;
   logic                  err_ff;
   logic                  mid_low;
   logic                  mid_high;
   logic                  samp_now;
   logic                  last_byte;

   initial
   begin
      if (LOAD_BYTES < 1 || LOAD_BYTES > (1 << `SOB_IDX_W))
         $error("sob_top: LOAD_BYTES out of range.");
   end

   function automatic logic byte_full(input logic [3:0] cnt);
      byte_full = (cnt == `SOB_BITS_PER_BYTE - 4'h1);
   endfunction

   assign samp_now  = !samp_done_ff;
   assign last_byte = (idx_ff == `SOB_IDX_W'(LOAD_BYTES - 1));

   // --------------------------------------------------------------------------
   // Serial clock generation.
   // --------------------------------------------------------------------------
   sob_sclk_div #(.DIV_W(DIV_W)) u_div
   (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .scl      (eeprom_scl),
      .mid_low  (mid_low),
      .mid_high (mid_high)
   );

   // --------------------------------------------------------------------------
   // Strap capture in the first cycle after reset release.
   // --------------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         samp_done_ff <= `SOB_RST_BIT;
         arb_ff       <= `SOB_RST_BIT;
      end
      else if (samp_now)
      begin
         samp_done_ff <= 1'b1;
         arb_ff       <= arbiter_enable_strap;
      end
   end

   // --------------------------------------------------------------------------
   // Configuration hold-off; cleared only by software.
   // --------------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cfg_dis_ff <= `SOB_RST_BIT;
      else if (samp_now)
         cfg_dis_ff <= config_disable_option;
      else if (misc_control_two_wr)
         cfg_dis_ff <= misc_control_two_cfg_dis;
   end

   // --------------------------------------------------------------------------
   // Sticky event flags; a new event wins over a clear.
   // --------------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         enum_pend_ff <= `SOB_RST_BIT;
      else if (hs_event)
         enum_pend_ff <= 1'b1;
      else if (hs_event_clr)
         enum_pend_ff <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         pme_pend_ff <= `SOB_RST_BIT;
      else if (pm_event)
         pme_pend_ff <= 1'b1;
      else if (pm_event_clr)
         pme_pend_ff <= 1'b0;
   end

   // --------------------------------------------------------------------------
   // Download engine: start, read command, then sequential byte reads.
   // --------------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_ff     <= SOB_IDLE;
         sda_oe_ff <= `SOB_RST_BIT;
         shift_ff  <= `SOB_RST_BYTE;
         bit_ff    <= `SOB_RST_BITCNT;
         idx_ff    <= '0;
         valid_ff  <= `SOB_RST_BIT;
         done_ff   <= `SOB_RST_BIT;
         err_ff    <= `SOB_RST_BIT;
      end
      else
      begin
         valid_ff <= 1'b0;
         case (st_ff)
            SOB_IDLE:
            begin
               if (samp_now && (eeprom_load_strap || eeprom_sda_i))
               begin
                  st_ff  <= SOB_START;
                  idx_ff <= '0;
               end
            end
            SOB_START:
            begin
               if (mid_high)
               begin
                  sda_oe_ff <= 1'b1;
                  shift_ff  <= `SOB_CTRL_READ;
                  bit_ff    <= `SOB_RST_BITCNT;
                  st_ff     <= SOB_CTRL;
               end
            end
            SOB_CTRL:
            begin
               if (mid_low)
                  sda_oe_ff <= !shift_ff[7];
               else if (mid_high)
               begin
                  shift_ff <= {shift_ff[6:0], 1'b0};
                  bit_ff   <= bit_ff + 4'h1;
                  if (byte_full(bit_ff))
                     st_ff <= SOB_CACK;
               end
            end
            SOB_CACK:
            begin
               if (mid_low)
                  sda_oe_ff <= 1'b0;
               else if (mid_high)
               begin
                  bit_ff <= `SOB_RST_BITCNT;
                  if (eeprom_sda_i)
                  begin
                     err_ff <= 1'b1;
                     st_ff  <= SOB_STOP;
                  end
                  else
                     st_ff <= SOB_RDBIT;
               end
            end
            SOB_RDBIT:
            begin
               if (mid_low)
                  sda_oe_ff <= 1'b0;
               else if (mid_high)
               begin
                  shift_ff <= {shift_ff[6:0], eeprom_sda_i};
                  bit_ff   <= bit_ff + 4'h1;
                  if (byte_full(bit_ff))
                  begin
                     valid_ff <= 1'b1;
                     st_ff    <= SOB_RACK;
                  end
               end
            end
            SOB_RACK:
            begin
               if (mid_low)
                  sda_oe_ff <= !last_byte;
               else if (mid_high)
               begin
                  bit_ff <= `SOB_RST_BITCNT;
                  if (last_byte)
                     st_ff <= SOB_STOP;
                  else
                  begin
                     idx_ff <= idx_ff + `SOB_IDX_W'(1);
                     st_ff  <= SOB_RDBIT;
                  end
               end
            end
            SOB_STOP:
            begin
               if (mid_low)
                  sda_oe_ff <= 1'b1;
               else if (mid_high)
               begin
                  sda_oe_ff <= 1'b0;
                  done_ff   <= 1'b1;
                  st_ff     <= SOB_IDLE;
               end
            end
            default:
               st_ff <= SOB_IDLE;
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Outputs.
   // --------------------------------------------------------------------------
   assign arb_enable         = arb_ff;
   assign cfg_retry          = cfg_dis_ff;
   assign enum_irq_o         = 1'b0;
   assign enum_irq_oe        = enum_pend_ff && !cfg_dis_ff;
   assign power_event_irq_o  = 1'b0;
   assign power_event_irq_oe = pme_pend_ff;
   assign eeprom_sda_o       = 1'b0;
   assign eeprom_sda_oe      = sda_oe_ff;
   assign load_busy          = (st_ff != SOB_IDLE);
   assign load_done          = done_ff;
   assign load_error         = err_ff;
   assign dl_byte            = shift_ff;
   assign dl_index           = idx_ff;
   assign dl_valid           = valid_ff;

   // --------------------------------------------------------------------------
   // Checks.
   // --------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic [DIV_W:0] per_ff;
   logic           rose_seen_ff;

   always_ff @(posedge sys_clk)
   begin
      if (rst || $rose(eeprom_scl))
         per_ff <= '0;
      else
         per_ff <= per_ff + (DIV_W+1)'(1);
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         rose_seen_ff <= 1'b0;
      else if ($rose(eeprom_scl))
         rose_seen_ff <= 1'b1;
   end

   sequence strap_load_s;
      samp_now && eeprom_load_strap;
   endsequence

   sequence sda_load_s;
      samp_now && eeprom_sda_i;
   endsequence

   sequence pm_set_s;
      pm_event ##1 1'b1;
   endsequence

   strap_load_a : assert property (strap_load_s |=> load_busy)
      else $error("Load strap did not start download.");
   sda_load_a : assert property (sda_load_s |=> load_busy ##1 load_busy)
      else $error("Serial data strap did not start download.");
   no_load_a : assert property (samp_now && !eeprom_load_strap && !eeprom_sda_i
      |=> !load_busy)
      else $error("Download started without a strap.");
   arb_strap_a : assert property (samp_now |=> arb_enable == $past(arbiter_enable_strap))
      else $error("Arbiter enable does not follow strap.");
   enum_hold_a : assert property (cfg_retry && !misc_control_two_wr |=> !enum_irq_oe)
      else $error("Hot-swap output asserted during hold-off.");
   cfg_clear_a : assert property (!samp_now && misc_control_two_wr && !misc_control_two_cfg_dis
      |=> !cfg_retry)
      else $error("Config cycles still retried after clear.");
   cfg_keep_a : assert property (!samp_now && cfg_retry && !misc_control_two_wr
      |=> cfg_retry)
      else $error("Hold-off ended without software clear.");
   scl_period_a : assert property ($rose(eeprom_scl) && rose_seen_ff
      |-> per_ff == (DIV_W+1)'(`SOB_SCL_PERIOD - 1))
      else $error("Serial clock period is wrong.");
   pme_set_a : assert property (pm_set_s |-> power_event_irq_oe)
      else $error("Power event output not asserted.");
   enum_set_a : assert property (hs_event && !cfg_retry && !$past(samp_now)
      |=> enum_irq_oe || cfg_retry)
      else $error("Hot-swap output not asserted on event.");
   reset_state_a : assert property (@(posedge sys_clk) disable iff (1'b0) rst
      |=> !load_busy && !power_event_irq_oe && !enum_irq_oe && !eeprom_sda_oe)
      else $error("Outputs not quiet after reset.");

endmodule

`default_nettype wire

/* testbench/sob_eeprom_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sob_eeprom_model
(
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic nack,
   input  wire logic hold_low,
   output logic      sda_oe
);
   logic [7:0] mem [0:255];
   logic [7:0] addr = 8'h00;
   logic [7:0] sh   = 8'h00;
   logic       act  = 1'b0;
   logic       rd   = 1'b0;
   logic       drv  = 1'b0;
   int         cnt  = 0;

   // Outside a transfer the bench may hold the line low to mask the data strap.
   assign sda_oe = act ? drv : hold_low;

   always @(negedge sda)
      if (scl)
      begin
         act = 1'b1;
         rd  = 1'b0;
         cnt = 0;
      end

   always @(posedge sda)
      if (scl)
         act = 1'b0;

   always @(posedge scl)
      if (act)
      begin
         if (!rd && cnt < 8)
            sh = {sh[6:0], sda};
         if (cnt == 8 && rd)
         begin
            addr = addr + 8'h01;
            act  = !sda;
         end
         if (cnt == 8 && !rd)
            rd = sh[0] && !nack;
         cnt = (cnt == 8) ? 0 : cnt + 1;
      end

   // Data bits change only while the clock is low, so no false start or stop.
   always @(negedge scl)
      if (act)
      begin
         if (cnt == 8)
            drv = !rd && !nack;
         else if (rd)
            drv = !mem[addr][3'd7 - cnt[2:0]];
         else
            drv = 1'b0;
      end
endmodule

`default_nettype wire

/* testbench/test_sob_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sob_defines.svh"

module test_sob_top;
   localparam int LB = 2;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic eeprom_load_strap = 1'b0;
   logic arbiter_enable_strap = 1'b0;
   logic config_disable_option = 1'b0;
   logic misc_control_two_wr = 1'b0;
   logic misc_control_two_cfg_dis = 1'b0;
   logic hs_event = 1'b0;
   logic hs_event_clr = 1'b0;
   logic pm_event = 1'b0;
   logic pm_event_clr = 1'b0;
   logic nack = 1'b0;
   logic hold_low = 1'b0;
   logic eeprom_sda_o, eeprom_sda_oe, eeprom_scl, arb_enable, cfg_retry, mem_oe;
   logic enum_irq_o, enum_irq_oe, power_event_irq_o, power_event_irq_oe;
   logic load_busy, load_done, load_error, dl_valid;
   logic [7:0] dl_byte;
   logic [`SOB_IDX_W-1:0] dl_index;
   int   failures = 0;
   int   n_tests = 0;
   int   seed = 44071;
   int   k, n, hi, lo;
   logic d, a;

   // Open-drain line with a pull-up: low while either party pulls it.
   wire sda_line = (eeprom_sda_oe ? eeprom_sda_o : 1'b1) && !mem_oe;

   always #10 sys_clk = ~sys_clk;

   sob_top #(.LOAD_BYTES(LB), .DIV_W(10)) i_sob_top (
      .sys_clk(sys_clk), .rst(rst), .eeprom_load_strap(eeprom_load_strap),
      .arbiter_enable_strap(arbiter_enable_strap), .config_disable_option(config_disable_option),
      .misc_control_two_wr(misc_control_two_wr), .misc_control_two_cfg_dis(misc_control_two_cfg_dis),
      .hs_event(hs_event), .hs_event_clr(hs_event_clr), .pm_event(pm_event),
      .pm_event_clr(pm_event_clr), .eeprom_sda_i(sda_line), .eeprom_sda_o(eeprom_sda_o),
      .eeprom_sda_oe(eeprom_sda_oe), .eeprom_scl(eeprom_scl), .arb_enable(arb_enable),
      .cfg_retry(cfg_retry), .enum_irq_o(enum_irq_o), .enum_irq_oe(enum_irq_oe),
      .power_event_irq_o(power_event_irq_o), .power_event_irq_oe(power_event_irq_oe),
      .load_busy(load_busy), .load_done(load_done), .load_error(load_error),
      .dl_byte(dl_byte), .dl_index(dl_index), .dl_valid(dl_valid));

   sob_eeprom_model i_sob_eeprom_model (.scl(eeprom_scl), .sda(sda_line), .nack(nack),
      .hold_low(hold_low), .sda_oe(mem_oe));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step();
      @(posedge sys_clk);
      #2;
   endtask

   // Straps are held over the capture edge, then scrambled to show they are ignored.
   task automatic do_reset(input logic ld, input logic arb, input logic dis, input logic hold);
      rst = 1'b1;
      step();
      eeprom_load_strap = ld;
      arbiter_enable_strap = arb;
      config_disable_option = dis;
      hold_low = hold;
      step();
      rst = 1'b0;
      step();
      step();
      eeprom_load_strap = 1'($random(seed));
      arbiter_enable_strap = 1'($random(seed));
      config_disable_option = 1'($random(seed));
      hold_low = 1'b0;
      step();
   endtask

   task automatic give_verdict();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge sys_clk);
      failures++;
      give_verdict();
   end

   initial
   begin
      for (k = 0; k < 256; k++)
         i_sob_eeprom_model.mem[k] = 8'($random(seed));
      do_reset(1'b1, 1'b1, 1'b1, 1'b1);
      check("arb_enable", arb_enable, 1'b1);
      check("cfg_retry", cfg_retry, 1'b1);
      check("load_busy", load_busy, 1'b1);
      hs_event = 1'b1;
      step();
      hs_event = 1'b0;
      step();
      check("enum_irq_oe", enum_irq_oe, 1'b0);
      for (k = 0; k < 7; k++)
      begin
         d = (k == 0 || k == 6) ? 1'b0 : 1'($random(seed));
         misc_control_two_wr = 1'b1;
         misc_control_two_cfg_dis = d;
         step();
         misc_control_two_wr = 1'b0;
         step();
         check("cfg_retry", cfg_retry, d);
         check("enum_irq_oe", enum_irq_oe, !d);
      end
      hs_event = 1'b1;
      hs_event_clr = 1'b1;
      pm_event = 1'b1;
      pm_event_clr = 1'b1;
      step();
      hs_event = 1'b0;
      pm_event = 1'b0;
      check("enum_irq_oe", enum_irq_oe, 1'b1);
      check("power_event_irq_oe", power_event_irq_oe, 1'b1);
      step();
      hs_event_clr = 1'b0;
      pm_event_clr = 1'b0;
      step();
      check("enum_irq_oe", enum_irq_oe, 1'b0);
      check("power_event_irq_oe", power_event_irq_oe, 1'b0);
      check("od_levels", {enum_irq_o, power_event_irq_o, eeprom_sda_o}, 3'h0);
      for (k = 0; k < 1100 && eeprom_scl !== 1'b0; k++) step();
      for (k = 0; k < 1100 && eeprom_scl !== 1'b1; k++) step();
      for (hi = 0; hi < 1100 && eeprom_scl === 1'b1; hi++) step();
      for (lo = 0; lo < 1100 && eeprom_scl === 1'b0; lo++) step();
      check("scl_period", 16'(hi + lo), 16'h0400);
      check("scl_high", 16'(hi), 16'h0200);
      for (n = 0; n < LB; n++)
      begin
         for (k = 0; k < 20000 && dl_valid !== 1'b1; k++) step();
         check("dl_byte", dl_byte, i_sob_eeprom_model.mem[n]);
         check("dl_index", dl_index, 16'(n));
         step();
      end
      for (k = 0; k < 4000 && load_busy !== 1'b0; k++) step();
      check("load_done", load_done, 1'b1);
      check("load_error", load_error, 1'b0);
      $display("test strap_download done");
      pm_event = 1'b1;
      step();
      pm_event = 1'b0;
      do_reset(1'b0, 1'b0, 1'b0, 1'b1);
      check("arb_enable", arb_enable, 1'b0);
      check("cfg_retry", cfg_retry, 1'b0);
      check("after_reset", {load_done, power_event_irq_oe, enum_irq_oe}, 3'h0);
      repeat (2100) step();
      check("load_busy", {load_busy, eeprom_sda_oe}, 2'h0);
      $display("test no_download done");
      nack = 1'b1;
      a = 1'($random(seed));
      do_reset(1'b0, a, 1'b0, 1'b0);
      check("load_busy", load_busy, 1'b1);
      check("arb_enable", arb_enable, a);
      for (k = 0; k < 15000 && load_busy !== 1'b0; k++) step();
      check("load_error", {load_busy, load_error}, 2'h1);
      nack = 1'b0;
      $display("test data_strap_nack done");
      give_verdict();
   end
endmodule

`default_nettype wire
